// File: rtl/isp_host_pkg.sv
// Constants for the serial programming host controller.
// Assumes a 20 MHz system clock and a target reached over reset/sck/mosi/miso pins.
package isp_host_pkg;
    localparam int unsigned SYS_CLK_HZ = 20000000;
    // Wait times in microseconds, as the target requires
    localparam int unsigned POWERUP_WAIT_US = 20000;
    localparam int unsigned FLASH_PAGE_WAIT_DELAY_US = 4500;
    localparam int unsigned EEPROM_BYTE_WAIT_DELAY_US = 4000;
    localparam int unsigned CHIP_ERASE_WAIT_DELAY_US = 4000;
    localparam int unsigned FUSE_WRITE_WAIT_DELAY_US = 4500;
    // Least times in whole cycles; clock rate truncated to whole MHz, no rounding up
    localparam int unsigned POWERUP_WAIT_CYC = (POWERUP_WAIT_US * (SYS_CLK_HZ / 1000000));
    localparam int unsigned FLASH_WAIT_CYC = (FLASH_PAGE_WAIT_DELAY_US * (SYS_CLK_HZ / 1000000));
    localparam int unsigned EEPROM_WAIT_CYC = (EEPROM_BYTE_WAIT_DELAY_US * (SYS_CLK_HZ / 1000000));
    localparam int unsigned ERASE_WAIT_CYC = (CHIP_ERASE_WAIT_DELAY_US * (SYS_CLK_HZ / 1000000));
    // Reset pulse used to resynchronise; target needs at least two of its cycles
    localparam int unsigned RESYNC_PULSE_CYC = 64;
    // Serial clock half period in system cycles
    localparam int unsigned SCK_HALF_CYC = 4;
    localparam logic [7:0] ENABLE_B1 = 8'hAC;
    localparam logic [7:0] ENABLE_B2 = 8'h53;
    localparam logic [7:0] ERASE_B2 = 8'h80;
    localparam logic [7:0] POLL_B1 = 8'hF0;
    localparam logic [7:0] BLANK_VALUE = 8'hFF;
    localparam int unsigned WAIT_W = 24;
    // Command codes on the user port
    localparam logic [2:0] CMD_ENABLE = 3'h0;
    localparam logic [2:0] CMD_RAW = 3'h1;
    localparam logic [2:0] CMD_ERASE = 3'h2;
    localparam logic [2:0] CMD_READ_FLASH = 3'h3;
    localparam logic [2:0] CMD_POLL = 3'h4;
    localparam logic [2:0] CMD_END = 3'h5;
    // Wait selection after a raw instruction
    localparam logic [1:0] WAIT_NONE = 2'h0;
    localparam logic [1:0] WAIT_FLASH = 2'h1;
    localparam logic [1:0] WAIT_EEPROM = 2'h2;
    localparam logic [1:0] WAIT_ERASE = 2'h3;
endpackage

// File: rtl/isp_host.sv
// Host controller driving a microcontroller's serial programming pins.
// Assumes the user issues one command at a time and waits for done.
`timescale 1ns/100ps
// Operation
// - Target samples mosi on sck rising; host changes mosi while sck low.
// - Target shifts miso on sck falling; host samples miso on sck rising.
// - Power-up holds reset and sck low; resync pulses reset high briefly.
// - Wait at least 20 ms in reset before the enable instruction.
// - All four bytes of every instruction are always sent.
// - Missing echo: pulse reset high, then send a fresh enable.
// - Flash page load carries 6 word-address bits and a data byte.
// - Low data byte is loaded before the high byte per word.
// - Flash page write carries the 8 high page-address bits; the bench target decodes only 4 (w[17:14]).
// - Without polling wait 4.5 ms after a flash page write.
// - EEPROM byte write self-erases; wait 4.0 ms without polling.
// - EEPROM page load uses 2 low bits; commit uses 4 high bits.
// - Raising reset ends programming and starts normal operation.
// - Value 0xFF cannot be polled; use the fixed flash wait.
// - Enable is AC 53 xx xx, accepted only with reset low.
// - Chip erase is AC 100xxxxx xx xx, erasing EEPROM and flash.
// - Read program memory: prefix 0010, high/low bit, word address.
// - Sck low and high phases each exceed 3 target cycles.
// - Poll instruction F0 returns busy in last bit of byte four.
module isp_host
    import isp_host_pkg::*;
#(
    parameter int unsigned POWERUP_CYC = POWERUP_WAIT_CYC,
    parameter int unsigned FLASH_CYC = FLASH_WAIT_CYC,
    parameter int unsigned EEPROM_CYC = EEPROM_WAIT_CYC,
    parameter int unsigned ERASE_CYC = ERASE_WAIT_CYC
) (
    // System
    input wire logic sys_clk,
    input wire logic rst_n,
    // User command port
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic [2:0] cmd_code,
    input wire logic [31:0] cmd_word,
    input wire logic [1:0] cmd_wait,
    output logic done,
    output logic [7:0] rd_data,
    output logic echo_ok,
    output logic busy_flag,
    // Target pins
    output logic tgt_reset,
    output logic tgt_sck,
    output logic tgt_mosi,
    input wire logic tgt_miso
);
    typedef enum logic [6:0] {
        ST_POWERUP = 7'h01,
        ST_IDLE = 7'h02,
        ST_SHIFT = 7'h04,
        ST_WAIT = 7'h08,
        ST_PULSE = 7'h10,
        ST_DONE = 7'h20,
        ST_RUN = 7'h40
    } state_t;

    state_t state_reg, state_next;
    logic [WAIT_W-1:0] cnt_reg, cnt_next;
    logic [2:0] half_reg, half_next;
    logic [5:0] bit_reg, bit_next;
    logic [31:0] tx_reg, tx_next;
    logic [31:0] rx_reg, rx_next;
    logic [2:0] code_reg, code_next;
    logic [1:0] wsel_reg, wsel_next;
    logic sck_reg, sck_next;
    logic rst_pin_reg, rst_pin_next;
    logic [7:0] rd_reg, rd_next;
    logic echo_reg, echo_next;
    logic busy_reg, busy_next;
    logic miso_s1_reg, miso_s2_reg;

    // Miso comes from the target's domain
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            miso_s1_reg <= 1'b0;
            miso_s2_reg <= 1'b0;
        end else begin
            miso_s1_reg <= tgt_miso;
            miso_s2_reg <= miso_s1_reg;
        end
    end

    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        half_next = half_reg;
        bit_next = bit_reg;
        tx_next = tx_reg;
        rx_next = rx_reg;
        code_next = code_reg;
        wsel_next = wsel_reg;
        sck_next = sck_reg;
        rst_pin_next = rst_pin_reg;
        rd_next = rd_reg;
        echo_next = echo_reg;
        busy_next = busy_reg;
        case (state_reg)
            ST_POWERUP: begin
                sck_next = 1'b0;
                rst_pin_next = 1'b0;
                if (cnt_reg >= WAIT_W'(POWERUP_CYC - 1)) begin
                    state_next = ST_IDLE;
                    cnt_next = '0;
                end else begin
                    cnt_next = cnt_reg + 1'b1;
                end
            end
            ST_IDLE, ST_RUN: begin
                if (cmd_valid) begin
                    code_next = cmd_code;
                    wsel_next = cmd_wait;
                    bit_next = '0;
                    half_next = '0;
                    cnt_next = '0;
                    rx_next = '0;
                    case (cmd_code)
                        CMD_END: begin
                            rst_pin_next = 1'b1;
                            state_next = ST_RUN;
                        end
                        CMD_ENABLE: begin
                            rst_pin_next = 1'b0;
                            tx_next = {ENABLE_B1, ENABLE_B2, 16'h0000};
                            wsel_next = WAIT_NONE;
                            state_next = (state_reg == ST_RUN) ? ST_POWERUP : ST_SHIFT;
                        end
                        CMD_ERASE: begin
                            tx_next = {ENABLE_B1, ERASE_B2, 16'h0000};
                            wsel_next = WAIT_ERASE;
                            state_next = ST_SHIFT;
                        end
                        CMD_READ_FLASH: begin
                            // Word bit0 selects high byte, rest is word address
                            tx_next = {4'h2, cmd_word[0], 3'h0, 6'h00,
                                cmd_word[10:1], 8'h00};
                            wsel_next = WAIT_NONE;
                            state_next = ST_SHIFT;
                        end
                        CMD_POLL: begin
                            tx_next = {POLL_B1, 24'h000000};
                            wsel_next = WAIT_NONE;
                            state_next = ST_SHIFT;
                        end
                        default: begin
                            // Flash/EEPROM load and write words and EEPROM read words are built by the user
                            tx_next = cmd_word;
                            state_next = ST_SHIFT;
                        end
                    endcase
                    if (state_reg == ST_RUN && cmd_code != CMD_ENABLE) begin
                        state_next = ST_RUN;
                    end
                end
            end
            ST_SHIFT: begin
                // Each sck phase lasts SCK_HALF_CYC system cycles
                if (half_reg == 3'(SCK_HALF_CYC - 1)) begin
                    half_next = '0;
                    if (!sck_reg) begin
                        sck_next = 1'b1;
                        rx_next = {rx_reg[30:0], miso_s2_reg};
                    end else begin
                        sck_next = 1'b0;
                        tx_next = {tx_reg[30:0], 1'b0};
                        if (bit_reg == 6'd31) begin
                            state_next = ST_WAIT;
                        end else begin
                            bit_next = bit_reg + 1'b1;
                        end
                    end
                end else begin
                    half_next = half_reg + 1'b1;
                end
            end
            ST_WAIT: begin
                rd_next = rx_reg[7:0];
                busy_next = rx_reg[0];
                if (code_reg == CMD_ENABLE) begin
                    echo_next = (rx_reg[15:8] == ENABLE_B2);
                end
                case (wsel_reg)
                    WAIT_FLASH: begin
                        if (cnt_reg >= WAIT_W'(FLASH_CYC - 1)) state_next = ST_DONE;
                        else cnt_next = cnt_reg + 1'b1;
                    end
                    WAIT_EEPROM: begin
                        if (cnt_reg >= WAIT_W'(EEPROM_CYC - 1)) state_next = ST_DONE;
                        else cnt_next = cnt_reg + 1'b1;
                    end
                    WAIT_ERASE: begin
                        if (cnt_reg >= WAIT_W'(ERASE_CYC - 1)) state_next = ST_DONE;
                        else cnt_next = cnt_reg + 1'b1;
                    end
                    default: begin
                        state_next = ST_DONE;
                    end
                endcase
            end
            ST_PULSE: begin
                rst_pin_next = 1'b1;
                if (cnt_reg >= WAIT_W'(RESYNC_PULSE_CYC - 1)) begin
                    rst_pin_next = 1'b0;
                    cnt_next = '0;
                    state_next = ST_POWERUP;
                end else begin
                    cnt_next = cnt_reg + 1'b1;
                end
            end
            ST_DONE: begin
                state_next = ST_IDLE;
                if (code_reg == CMD_ENABLE && !echo_reg) begin
                    cnt_next = '0;
                    // Reset rises as the pulse state is entered, so the pulse is a full count long
                    rst_pin_next = 1'b1;
                    state_next = ST_PULSE;
                end
            end
            default: begin
                state_next = ST_POWERUP;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_POWERUP;
            cnt_reg <= '0;
            half_reg <= '0;
            bit_reg <= '0;
            tx_reg <= '0;
            rx_reg <= '0;
            code_reg <= CMD_ENABLE;
            wsel_reg <= WAIT_NONE;
            sck_reg <= 1'b0;
            rst_pin_reg <= 1'b0;
            rd_reg <= 8'h00;
            echo_reg <= 1'b0;
            busy_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            half_reg <= half_next;
            bit_reg <= bit_next;
            tx_reg <= tx_next;
            rx_reg <= rx_next;
            code_reg <= code_next;
            wsel_reg <= wsel_next;
            sck_reg <= sck_next;
            rst_pin_reg <= rst_pin_next;
            rd_reg <= rd_next;
            echo_reg <= echo_next;
            busy_reg <= busy_next;
        end
    end

    assign cmd_ready = (state_reg == ST_IDLE) || (state_reg == ST_RUN);
    assign done = (state_reg == ST_DONE);
    assign rd_data = rd_reg;
    assign echo_ok = echo_reg;
    assign busy_flag = busy_reg;
    assign tgt_reset = rst_pin_reg;
    assign tgt_sck = sck_reg;
    assign tgt_mosi = tx_reg[31];

    a_mosi_stable: assert property (@(posedge sys_clk) disable iff (!rst_n)
        sck_reg |-> $stable(tx_reg[31])) else $error("mosi changed while sck high");
    a_sck_phase_len: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(sck_reg) |-> sck_reg [*4]) else $error("sck high phase too short");
    a_reset_low_shift: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state_reg == ST_SHIFT) |-> !rst_pin_reg) else $error("reset high during shift");
    a_powerup_sck_low: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state_reg == ST_POWERUP) |-> !sck_reg && !rst_pin_reg) else $error("powerup pins");
    a_bad_echo_pulse: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (done && code_reg == CMD_ENABLE && !echo_reg) |=> rst_pin_reg) else $error("no resync");
    a_four_bytes: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state_reg == ST_SHIFT && state_next == ST_WAIT) |-> bit_reg == 6'd31)
        else $error("short instruction");
    a_end_reset_high: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (cmd_ready && cmd_valid && cmd_code == CMD_END) |=> rst_pin_reg)
        else $error("end did not raise reset");
    a_flash_wait: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state_reg == ST_WAIT && wsel_reg == WAIT_FLASH && cnt_reg == '0) |-> !done [*2])
        else $error("flash wait skipped");
    c_enable: cover property (@(posedge sys_clk) done && code_reg == CMD_ENABLE && echo_reg);
    c_resync: cover property (@(posedge sys_clk) state_reg == ST_PULSE);
    c_erase: cover property (@(posedge sys_clk) done && code_reg == CMD_ERASE);
endmodule

// File: bench/isp_target_model.sv
// Behavioural target device for the serial programming host.
// Assumes the host drives reset, sck and mosi; nosync spoils the echo and the enable.
`timescale 1ns/100ps
module isp_target_model #(
    parameter realtime BUSY_NS = 30000.0
) (
    // Target pins
    input wire logic tgt_reset,
    input wire logic tgt_sck,
    input wire logic tgt_mosi,
    output logic tgt_miso,
    // Fault control
    input wire logic nosync
);
    logic [7:0] fl [2048];
    logic [7:0] ee [128];
    logic [7:0] pb [128];
    logic [31:0] rx;
    logic [7:0] tx;
    logic en, bee;
    logic [3:0] bpg;
    logic [6:0] bea;
    realtime bend;
    int cnt;
    initial begin
        foreach (fl[i]) fl[i] = 8'hFF;
        foreach (ee[i]) ee[i] = 8'hFF;
        foreach (pb[i]) pb[i] = 8'hFF;
        {en, bee, bpg, bea, tx, tgt_miso} = '0;
        bend = 0.0;
        cnt = 0;
    end
    function automatic logic bsy();
        return $realtime < bend;
    endfunction
    function automatic logic [7:0] rd4(input logic [23:0] r);
        if (!en) return 8'h00;
        if (r[23:20] == 4'h2)
            return (bsy() && !bee && r[9:6] == bpg) ? 8'hFF : fl[{r[9:0], r[19]}];
        if (r[23:16] == 8'hA0)
            return (bsy() && bee && r[6:0] == bea) ? 8'hFF : ee[r[6:0]];
        return {7'h00, bsy() && r[23:16] == 8'hF0};
    endfunction
    // Acts only on whole four-byte frames
    task automatic run(input logic [31:0] w);
        if (w[31:16] == 16'hAC53) en = !nosync;
        else if (en && w[31:21] == {8'hAC, 3'b100}) begin
            foreach (fl[i]) fl[i] = 8'hFF;
            foreach (ee[i]) ee[i] = 8'hFF;
        end else if (en && w[31:28] == 4'h4 && w[26:24] == 3'h0)
            pb[{w[13:8], w[27]}] = w[7:0];
        else if (en && w[31:24] == 8'h4C) begin
            foreach (pb[i]) fl[{w[17:14], i[6:0]}] &= pb[i];
            foreach (pb[i]) pb[i] = 8'hFF;
            bee = 1'b0;
            bpg = w[17:14];
            bend = $realtime + BUSY_NS;
        end else if (en && w[31:24] == 8'hC0) begin
            ee[w[14:8]] = w[7:0];
            bee = 1'b1;
            bea = w[14:8];
            bend = $realtime + BUSY_NS;
        end
    endtask
    always @(posedge tgt_reset) begin
        en = 1'b0;
        cnt = 0;
    end
    // Released line wanders while the device runs normally
    always #37 if (tgt_reset) tgt_miso = ~tgt_miso;
    always @(posedge tgt_sck) if (!tgt_reset) begin
        rx = {rx[30:0], tgt_mosi};
        cnt++;
        if (cnt == 16) tx = (rx[15:0] == 16'hAC53 && !nosync) ? 8'h53 : 8'h00;
        if (cnt == 24) tx = rd4(rx[23:0]);
        if (cnt == 32) begin
            run(rx);
            cnt = 0;
        end
    end
    always @(negedge tgt_sck) if (!tgt_reset) tgt_miso = tx[7 - cnt[2:0]];
endmodule

// File: bench/isp_host_tb_top.sv
// Self-checking bench for the serial programming host.
// Assumes the behavioural target in isp_target_model.sv on the far side.
`timescale 1ns/100ps
module isp_host_tb_top;
    import isp_host_pkg::*;
    localparam int unsigned PW = 40;
    logic sys_clk, rst_n, cmd_valid, cmd_ready, done, echo_ok, busy_flag;
    logic tgt_reset, tgt_sck, tgt_mosi, tgt_miso, nosync;
    logic [2:0] cmd_code;
    logic [31:0] cmd_word, sr;
    logic [1:0] cmd_wait;
    logic [7:0] rd_data;
    logic [7:0] efl [2048];
    int fails, n_tests, pulses;
    isp_host #(.POWERUP_CYC(PW), .FLASH_CYC(700), .EEPROM_CYC(700), .ERASE_CYC(40)) dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd_code(cmd_code), .cmd_word(cmd_word), .cmd_wait(cmd_wait), .done(done),
        .rd_data(rd_data), .echo_ok(echo_ok), .busy_flag(busy_flag), .tgt_reset(tgt_reset),
        .tgt_sck(tgt_sck), .tgt_mosi(tgt_mosi), .tgt_miso(tgt_miso));
    isp_target_model tgt (.tgt_reset(tgt_reset), .tgt_sck(tgt_sck), .tgt_mosi(tgt_mosi),
        .tgt_miso(tgt_miso), .nosync(nosync));
    always #25 sys_clk = ~sys_clk;
    always @(posedge tgt_sck) sr <= {sr[30:0], tgt_mosi};
    always @(posedge tgt_reset) pulses++;
    // Every serial clock phase inside a frame lasts at least the host's half period
    realtime t_sck = 0.0;
    always @(tgt_sck) begin
        if (!tgt_reset && t_sck > 0.0) chk($realtime - t_sck >= SCK_HALF_CYC * 50.0, 1, "sck phase");
        t_sck = $realtime;
    end
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string s);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t %s: got %h expected %h", $time, s, got, exp);
        end
    endtask
    task automatic cmd(input logic [2:0] c, input logic [31:0] w, input logic [1:0] wt);
        int n;
        @(posedge sys_clk);
        cmd_valid <= 1'b1;
        cmd_code <= c;
        cmd_word <= w;
        cmd_wait <= wt;
        n = 0;
        @(negedge sys_clk);
        while (cmd_ready !== 1'b1 && n < 3000) begin
            n++;
            @(negedge sys_clk);
        end
        @(posedge sys_clk);
        cmd_valid <= 1'b0;
        @(negedge sys_clk);
        // Ending the session gives no done pulse; reset rises at the take edge
        while (c != CMD_END && done !== 1'b1 && n < 6000) begin
            n++;
            @(negedge sys_clk);
        end
        if (n >= 6000) chk(0, 1, "command hung");
    endtask
    task automatic raw(input logic [31:0] w, input logic [1:0] wt);
        cmd(CMD_RAW, w, wt);
        chk(sr, w, "mosi word");
    endtask
    task automatic rd(input logic [9:0] a, input logic h, input logic [7:0] e);
        cmd(CMD_READ_FLASH, {21'h0, a, h}, WAIT_NONE);
        chk(sr, {4'h2, h, 9'h0, a, 8'h00}, "read word");
        chk({24'h0, rd_data}, {24'h0, e}, "flash read");
    endtask
    task automatic er(input logic [6:0] a, input logic [7:0] e);
        raw({8'hA0, 9'h0, a, 8'h00}, WAIT_NONE);
        chk({24'h0, rd_data}, {24'h0, e}, "eeprom read");
    endtask
    task automatic idle();
        int k;
        k = 0;
        do begin
            cmd(CMD_POLL, 0, WAIT_NONE);
            k++;
        end while (busy_flag !== 1'b0 && k < 8);
        chk({31'h0, busy_flag}, 0, "poll idle");
    endtask
    initial begin
        #(60000 * 50);
        fails++;
        end_sim();
    end
    initial begin
        logic [3:0] pg;
        logic [5:0] offs [4];
        logic [7:0] d;
        logic [6:0] ea;
        int n, p0;
        {sys_clk, rst_n, cmd_valid, cmd_code, cmd_word, cmd_wait} = '0;
        nosync = 1'b1;
        {fails, n_tests, pulses} = '0;
        foreach (efl[i]) efl[i] = 8'hFF;
        n = $urandom(32'h68FF);
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        n = 0;
        @(negedge sys_clk);
        while (cmd_ready !== 1'b1 && n < 200) begin
            chk({tgt_reset, tgt_sck}, 0, "power-up pins");
            n++;
            @(negedge sys_clk);
        end
        chk(n >= PW - 1, 1, "power-up wait");
        $display("power-up test done");
        p0 = pulses;
        cmd(CMD_ENABLE, 0, WAIT_NONE);
        chk(echo_ok, 0, "echo out of sync");
        nosync <= 1'b0;
        cmd(CMD_ENABLE, 0, WAIT_NONE);
        chk(sr[31:16], 16'hAC53, "enable word");
        chk({echo_ok, tgt_reset}, 2'b10, "echo in sync");
        chk(pulses, p0 + 1, "resync pulse");
        $display("enable test done");
        for (int p = 0; p < 2; p++) begin
            pg = p ? pg + 4'h1 : 4'($urandom);
            for (int k = 0; k < 4; k++) begin
                offs[k] = {k[1:0], 1'b0, 3'($urandom)};
                for (int h = 0; h < 2; h++) begin
                    d = (k == 0 && h == 1) ? 8'hFF : 8'($urandom);
                    raw({4'h4, h[0], 13'h0, offs[k], d}, WAIT_NONE);
                    efl[{pg, offs[k], h[0]}] = d;
                end
            end
            raw({8'h4C, 6'h0, pg, 14'h0}, p ? WAIT_FLASH : WAIT_NONE);
            if (p == 0) begin
                rd({pg, offs[1]}, 1'b0, 8'hFF);
                cmd(CMD_POLL, 0, WAIT_NONE);
                chk({sr[31:24], 7'h0, busy_flag}, {8'hF0, 8'h01}, "poll busy");
                idle();
            end
            for (int k = 0; k < 4; k++) begin
                for (int h = 0; h < 2; h++) rd({pg, offs[k]}, h[0], efl[{pg, offs[k], h[0]}]);
            end
            rd({pg, 6'h08}, 1'b0, 8'hFF);
        end
        $display("flash test done");
        ea = 7'($urandom);
        d = 8'($urandom) & 8'h7F;
        raw({8'hC0, 9'h0, ea, d}, WAIT_NONE);
        er(ea, 8'hFF);
        idle();
        er(ea, d);
        raw({8'hC0, 9'h0, ea, ~d}, WAIT_EEPROM);
        er(ea, ~d);
        $display("eeprom test done");
        cmd(CMD_ERASE, 0, WAIT_ERASE);
        chk(sr[31:21], {8'hAC, 3'b100}, "erase word");
        rd({pg, offs[3]}, 1'b1, 8'hFF);
        er(ea, 8'hFF);
        cmd(CMD_END, 0, WAIT_NONE);
        chk(tgt_reset, 1, "session end");
        $display("erase and end test done");
        end_sim();
    end
endmodule
